// file: rtl/port_pin_map.svh
`ifndef PORT_PIN_MAP_SVH
`define PORT_PIN_MAP_SVH

`define ADDR_W            8
`define DATA_W            8
`define PM_W              6
`define PP_W              8
`define SYNC_STAGES       2

`define PM_PULL_EN_OFS    8'h14
`define PM_PULL_SEL_OFS   8'h15
`define PM_OD_OFS         8'h16
`define PP_DATA_OFS       8'h18
`define PP_LEVEL_OFS      8'h19
`define PP_DIR_OFS        8'h1a
`define PP_RDR_OFS        8'h1b
`define PP_PULL_EN_OFS    8'h1c
`define PP_PULL_SEL_OFS   8'h1d

`define PM_PULL_EN_RST    6'h3f
`define PM_PULL_SEL_RST   6'h00
`define PM_OD_RST         6'h00
`define PP_REG_RST        8'h00

`endif

// file: rtl/port_pin_pkg.sv
package port_pin_pkg;
  `include "port_pin_map.svh"

  typedef struct packed {
    logic [`PM_W-1:0] pm_pull_en;
    logic [`PM_W-1:0] pm_pull_sel;
    logic [`PM_W-1:0] pm_od;
    logic [`PP_W-1:0] pp_data;
    logic [`PP_W-1:0] pp_dir;
    logic [`PP_W-1:0] pp_rdr;
    logic [`PP_W-1:0] pp_pull_en;
    logic [`PP_W-1:0] pp_pull_sel;
  } cfg_t;

  typedef struct packed {
    cfg_t               cfg;
    logic [`DATA_W-1:0] rdata;
  } top_state_t;

  typedef struct packed {
    logic [`PM_W-1:0] pm_oe;
    logic [`PM_W-1:0] pm_out;
    logic [`PM_W-1:0] pm_od;
    logic [`PM_W-1:0] pm_pull_en;
    logic [`PM_W-1:0] pm_pull_sel;
    logic [`PP_W-1:0] pp_oe;
    logic [`PP_W-1:0] pp_out;
    logic [`PP_W-1:0] pp_rdr;
    logic [`PP_W-1:0] pp_pull_en;
    logic [`PP_W-1:0] pp_pull_sel;
  } pad_state_t;
endpackage : port_pin_pkg

// file: rtl/pad_cfg_if.sv
`timescale 1ns/1ps
`include "port_pin_map.svh"
interface pad_cfg_if;
  import port_pin_pkg::*;
  cfg_t             cfg;
  logic [`PM_W-1:0] pm_dir;
  logic [`PM_W-1:0] pm_dout;
  pad_state_t       pads;

  modport src  (output cfg, output pm_dir, output pm_dout, input pads);
  modport ctrl (input cfg, input pm_dir, input pm_dout, output pads);
endinterface : pad_cfg_if

// file: rtl/pin_sync.sv
`timescale 1ns/1ps
`include "port_pin_map.svh"
module pin_sync #(
  parameter int W = `PP_W
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst_b,
  // pin levels
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] pin_sync_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_state_t;

  sync_state_t s_q;
  sync_state_t s_d;

  always_comb begin
    s_d    = s_q;
    s_d.s1 = pin_in;
    s_d.s2 = s_q.s1;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pin_sync_out = s_q.s2;
endmodule : pin_sync

// file: rtl/pad_ctrl.sv
`timescale 1ns/1ps
`include "port_pin_map.svh"
module pad_ctrl
  import port_pin_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // configuration in, pad controls out
  pad_cfg_if.ctrl  pc
);
  pad_state_t s_q;
  pad_state_t s_d;

  always_comb begin
    s_d = s_q;
    // open-drain only drives low; high data releases the pin
    s_d.pm_out      = pc.pm_dout & ~pc.cfg.pm_od;
    s_d.pm_oe       = pc.pm_dir & ~(pc.cfg.pm_od & pc.pm_dout);
    s_d.pm_od       = pc.cfg.pm_od & pc.pm_dir;
    // pull on for inputs or open-drain outputs; pull-down for inputs only
    s_d.pm_pull_en  = pc.cfg.pm_pull_en & (~pc.pm_dir | pc.cfg.pm_od)
                      & ~(pc.cfg.pm_pull_sel & pc.pm_dir);
    s_d.pm_pull_sel = pc.cfg.pm_pull_sel;
    s_d.pp_oe       = pc.cfg.pp_dir;
    s_d.pp_out      = pc.cfg.pp_data;
    s_d.pp_rdr      = pc.cfg.pp_rdr & pc.cfg.pp_dir;
    s_d.pp_pull_en  = pc.cfg.pp_pull_en & ~pc.cfg.pp_dir;
    s_d.pp_pull_sel = pc.cfg.pp_pull_sel;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q            <= '0;
      s_q.pm_pull_en <= `PM_PULL_EN_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign pc.pads = s_q;
endmodule : pad_ctrl

// file: rtl/port_pin_config_regs.sv
`timescale 1ns/1ps
`include "port_pin_map.svh"
module port_pin_config_regs
  import port_pin_pkg::*;
(
  // clock and reset
  input  wire logic               ref_clk,
  input  wire logic               rst_b,
  // register port
  input  wire logic [`ADDR_W-1:0] addr,
  input  wire logic [`DATA_W-1:0] wdata,
  input  wire logic               wr,
  input  wire logic               rd,
  output logic      [`DATA_W-1:0] rdata,
  // port M core side: data and direction kept elsewhere
  input  wire logic [`PM_W-1:0]   portm_dir_in,
  input  wire logic [`PM_W-1:0]   portm_dout_in,
  // port M pad controls
  output logic      [`PM_W-1:0]   portm_oe,
  output logic      [`PM_W-1:0]   portm_out,
  output logic      [`PM_W-1:0]   portm_od,
  output logic      [`PM_W-1:0]   portm_pull_en,
  output logic      [`PM_W-1:0]   portm_pull_sel,
  // port P pins and pad controls
  input  wire logic [`PP_W-1:0]   portp_pin_in,
  output logic      [`PP_W-1:0]   portp_oe,
  output logic      [`PP_W-1:0]   portp_out,
  output logic      [`PP_W-1:0]   portp_rdr,
  output logic      [`PP_W-1:0]   portp_pull_en,
  output logic      [`PP_W-1:0]   portp_pull_sel
);
  localparam logic [`DATA_W-`PM_W-1:0] PM_PAD = '0;

  top_state_t       s_q;
  top_state_t       s_d;
  logic [`PP_W-1:0] pin_lvl;

  pad_cfg_if pc ();

  pin_sync #(
    .W            (`PP_W)
  ) u_sync (
    .ref_clk      (ref_clk),
    .rst_b        (rst_b),
    .pin_in       (portp_pin_in),
    .pin_sync_out (pin_lvl)
  );

  pad_ctrl u_pad (
    .ref_clk      (ref_clk),
    .rst_b        (rst_b),
    .pc           (pc.ctrl)
  );

  assign pc.cfg     = s_q.cfg;
  assign pc.pm_dir  = portm_dir_in;
  assign pc.pm_dout = portm_dout_in;

  // register writes and one-cycle read data
  always_comb begin
    s_d       = s_q;
    s_d.rdata = '0;
    if (wr) begin
      unique case (addr)
        `PM_PULL_EN_OFS:  s_d.cfg.pm_pull_en  = wdata[`PM_W-1:0];
        `PM_PULL_SEL_OFS: s_d.cfg.pm_pull_sel = wdata[`PM_W-1:0];
        `PM_OD_OFS:       s_d.cfg.pm_od       = wdata[`PM_W-1:0];
        `PP_DATA_OFS:     s_d.cfg.pp_data     = wdata;
        `PP_DIR_OFS:      s_d.cfg.pp_dir      = wdata;
        `PP_RDR_OFS:      s_d.cfg.pp_rdr      = wdata;
        `PP_PULL_EN_OFS:  s_d.cfg.pp_pull_en  = wdata;
        `PP_PULL_SEL_OFS: s_d.cfg.pp_pull_sel = wdata;
        default:          s_d.cfg             = s_q.cfg;
      endcase
    end
    if (rd) begin
      unique case (addr)
        `PM_PULL_EN_OFS:  s_d.rdata = {PM_PAD, s_q.cfg.pm_pull_en};
        `PM_PULL_SEL_OFS: s_d.rdata = {PM_PAD, s_q.cfg.pm_pull_sel};
        `PM_OD_OFS:       s_d.rdata = {PM_PAD, s_q.cfg.pm_od};
        `PP_DATA_OFS:     s_d.rdata = (s_q.cfg.pp_dir & s_q.cfg.pp_data)
                                      | (~s_q.cfg.pp_dir & pin_lvl);
        `PP_LEVEL_OFS:    s_d.rdata = pin_lvl;
        `PP_DIR_OFS:      s_d.rdata = s_q.cfg.pp_dir;
        `PP_RDR_OFS:      s_d.rdata = s_q.cfg.pp_rdr;
        `PP_PULL_EN_OFS:  s_d.rdata = s_q.cfg.pp_pull_en;
        `PP_PULL_SEL_OFS: s_d.rdata = s_q.cfg.pp_pull_sel;
        default:          s_d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q                 <= '0;
      s_q.cfg.pm_pull_en  <= `PM_PULL_EN_RST;
      s_q.cfg.pm_pull_sel <= `PM_PULL_SEL_RST;
      s_q.cfg.pm_od       <= `PM_OD_RST;
      s_q.cfg.pp_pull_en  <= `PP_REG_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata          = s_q.rdata;
  assign portm_oe       = pc.pads.pm_oe;
  assign portm_out      = pc.pads.pm_out;
  assign portm_od       = pc.pads.pm_od;
  assign portm_pull_en  = pc.pads.pm_pull_en;
  assign portm_pull_sel = pc.pads.pm_pull_sel;
  assign portp_oe       = pc.pads.pp_oe;
  assign portp_out      = pc.pads.pp_out;
  assign portp_rdr      = pc.pads.pp_rdr;
  assign portp_pull_en  = pc.pads.pp_pull_en;
  assign portp_pull_sel = pc.pads.pp_pull_sel;

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  pm_pull_write_a: assert property (
    wr && addr == `PM_PULL_EN_OFS |=> ##1 portm_pull_en ==
      ($past(wdata[`PM_W-1:0], 2) & (~$past(portm_dir_in) | $past(s_q.cfg.pm_od))
       & ~($past(s_q.cfg.pm_pull_sel) & $past(portm_dir_in))))
    else $error("port M pull enable not applied after write");

  pm_pull_gate_a: assert property (
    ##1 ($past(~s_q.cfg.pm_od & portm_dir_in) & portm_pull_en) == '0)
    else $error("pull active on a push-pull port M output");

  reset_pulls_a: assert property (
    $rose(rst_b) |-> s_q.cfg.pm_pull_en == `PM_PULL_EN_RST && s_q.cfg.pm_pull_sel == '0
                     && portp_pull_en == '0)
    else $error("pull reset values wrong");

  pm_pulldown_in_a: assert property (
    ##1 (portm_pull_en & $past(s_q.cfg.pm_pull_sel & portm_dir_in)) == '0)
    else $error("port M pull-down active on an output");

  pm_pulldown_on_a: assert property (
    ##1 portm_pull_sel == $past(s_q.cfg.pm_pull_sel))
    else $error("port M pull select not forwarded");

  od_low_only_a: assert property (
    (portm_od & portm_oe & portm_out) == '0 && (portm_od & portm_out) == '0)
    else $error("open-drain pin drives high");

  od_release_a: assert property (
    ##1 portm_oe == $past(portm_dir_in & ~(s_q.cfg.pm_od & portm_dout_in)))
    else $error("open-drain release wrong");

  od_input_a: assert property (
    ##1 portm_od == $past(s_q.cfg.pm_od & portm_dir_in))
    else $error("open-drain applied to an input");

  data_read_a: assert property (
    rd && addr == `PP_DATA_OFS |=> rdata ==
      (($past(s_q.cfg.pp_dir) & $past(s_q.cfg.pp_data)) | (~$past(s_q.cfg.pp_dir) & $past(pin_lvl))))
    else $error("port P data read mixes latch and pins wrongly");

  pin_path_a: assert property (
    rst_b |-> ##2 pin_lvl == $past(portp_pin_in, 2))
    else $error("pin synchronizer depth not two");

  level_read_a: assert property (
    rd && addr == `PP_LEVEL_OFS |=> rdata == $past(pin_lvl))
    else $error("pin level read wrong");

  level_write_a: assert property (
    wr && addr == `PP_LEVEL_OFS |=> $stable(s_q.cfg))
    else $error("pin level write changed state");

  dir_oe_a: assert property (
    wr && addr == `PP_DIR_OFS |=> ##1 portp_oe == $past(wdata, 2))
    else $error("direction write not seen at output enable");

  rdr_input_a: assert property (
    ##1 portp_rdr == $past(s_q.cfg.pp_rdr & s_q.cfg.pp_dir))
    else $error("reduced drive on an input");

  pp_pull_in_a: assert property (
    ##1 portp_pull_en == $past(s_q.cfg.pp_pull_en & ~s_q.cfg.pp_dir))
    else $error("port P pull active on an output");

  pp_pull_sel_a: assert property (
    wr && addr == `PP_PULL_SEL_OFS |=> ##1 portp_pull_sel == $past(wdata, 2))
    else $error("port P pull select not forwarded");

  read_idle_a: assert property (
    !rd |=> rdata == '0)
    else $error("read data outside the read answer cycle");

  pp_out_a: assert property (
    wr && addr == `PP_DATA_OFS |=> ##1 portp_out == $past(wdata, 2))
    else $error("port P data latch not driven out");

  pm_sel_write_a: assert property (
    wr && addr == `PM_PULL_SEL_OFS |=> ##1 portm_pull_sel == $past(wdata[`PM_W-1:0], 2))
    else $error("port M pull select write not applied");

  pm_od_write_a: assert property (
    wr && addr == `PM_OD_OFS |=> ##1 portm_od == ($past(wdata[`PM_W-1:0], 2) & $past(portm_dir_in)))
    else $error("port M open-drain write not applied");

  pp_rdr_write_a: assert property (
    wr && addr == `PP_RDR_OFS |=> ##1 portp_rdr == ($past(wdata, 2) & $past(s_q.cfg.pp_dir)))
    else $error("reduced drive write not applied");

  pp_pull_write_a: assert property (
    wr && addr == `PP_PULL_EN_OFS |=> ##1 portp_pull_en == ($past(wdata, 2) & ~$past(s_q.cfg.pp_dir)))
    else $error("port P pull enable write not applied");

  pm_push_pull_a: assert property (
    rst_b |-> ##1 ($past(portm_dir_in & ~s_q.cfg.pm_od) & (~portm_oe | (portm_out ^ $past(portm_dout_in)))) == '0)
    else $error("push-pull port M output not driven with data");

  od_drive_low_a: assert property (
    rst_b |-> ##1 ($past(portm_dir_in & s_q.cfg.pm_od & ~portm_dout_in) & (~portm_oe | portm_out)) == '0)
    else $error("open-drain pin not driven low for data 0");

  od_release_hi_a: assert property (
    rst_b |-> ##1 ($past(portm_dir_in & s_q.cfg.pm_od & portm_dout_in) & portm_oe) == '0)
    else $error("open-drain pin driven for data 1");

  pm_input_oe_a: assert property (
    rst_b |-> ##1 ($past(~portm_dir_in) & (portm_oe | portm_od)) == '0)
    else $error("port M input pin driven");

  pm_input_pull_a: assert property (
    rst_b |-> ##1 ($past(~portm_dir_in) & (portm_pull_en ^ $past(s_q.cfg.pm_pull_en))) == '0)
    else $error("port M input pull does not follow enable");

  od_pullup_a: assert property (
    rst_b |-> ##1 ($past(portm_dir_in & s_q.cfg.pm_od & ~s_q.cfg.pm_pull_sel)
                   & (portm_pull_en ^ $past(s_q.cfg.pm_pull_en))) == '0)
    else $error("open-drain pull-up does not follow enable");

  pm_out_od_a: assert property (
    rst_b |-> ##1 (portm_out & $past(s_q.cfg.pm_od)) == '0)
    else $error("port M output value high on an open-drain pin");

  pp_oe_dir_a: assert property (
    rst_b |-> ##1 portp_oe == $past(s_q.cfg.pp_dir))
    else $error("port P output enable does not follow direction");

  pp_out_data_a: assert property (
    rst_b |-> ##1 portp_out == $past(s_q.cfg.pp_data))
    else $error("port P output value does not follow latch");

  pp_sel_copy_a: assert property (
    rst_b |-> ##1 portp_pull_sel == $past(s_q.cfg.pp_pull_sel))
    else $error("port P pull select does not follow register");

  pp_out_pull_a: assert property (
    (portp_pull_en & portp_oe) == '0)
    else $error("pull active on a port P output");

  pp_rdr_in_a: assert property (
    (portp_rdr & ~portp_oe) == '0)
    else $error("reduced drive on a port P input");

  pp_pull_reset_a: assert property (
    $rose(rst_b) |=> portp_pull_en == '0)
    else $error("port P pull enabled after reset");

  pm_reset_pads_a: assert property (
    $rose(rst_b) |-> portm_pull_en == `PM_PULL_EN_RST && portm_pull_sel == '0)
    else $error("port M pad pulls wrong after reset");

  sync_reset_a: assert property (
    $rose(rst_b) |-> pin_lvl == '0)
    else $error("pin synchronizer not cleared by reset");

  pm_pad_read_a: assert property (
    rd && (addr == `PM_PULL_EN_OFS || addr == `PM_PULL_SEL_OFS || addr == `PM_OD_OFS)
    |=> rdata[`DATA_W-1:`PM_W] == '0)
    else $error("port M register upper bits not zero");

  unmapped_read_a: assert property (
    rd && !(addr inside {`PM_PULL_EN_OFS, `PM_PULL_SEL_OFS, `PM_OD_OFS, `PP_DATA_OFS, `PP_LEVEL_OFS,
                         `PP_DIR_OFS, `PP_RDR_OFS, `PP_PULL_EN_OFS, `PP_PULL_SEL_OFS}) |=> rdata == '0)
    else $error("unmapped read returned data");

  unmapped_write_a: assert property (
    wr && !(addr inside {`PM_PULL_EN_OFS, `PM_PULL_SEL_OFS, `PM_OD_OFS, `PP_DATA_OFS,
                         `PP_DIR_OFS, `PP_RDR_OFS, `PP_PULL_EN_OFS, `PP_PULL_SEL_OFS}) |=> $stable(s_q.cfg))
    else $error("write to a read-only or unmapped offset changed state");

  pm_en_read_a: assert property (
    rd && addr == `PM_PULL_EN_OFS |=> rdata == {PM_PAD, $past(s_q.cfg.pm_pull_en)})
    else $error("port M pull enable read wrong");

  pm_sel_read_a: assert property (
    rd && addr == `PM_PULL_SEL_OFS |=> rdata == {PM_PAD, $past(s_q.cfg.pm_pull_sel)})
    else $error("port M pull select read wrong");

  pm_od_read_a: assert property (
    rd && addr == `PM_OD_OFS |=> rdata == {PM_PAD, $past(s_q.cfg.pm_od)})
    else $error("port M open-drain read wrong");

  dir_read_a: assert property (
    rd && addr == `PP_DIR_OFS |=> rdata == $past(s_q.cfg.pp_dir))
    else $error("port P direction read wrong");

  rdr_read_a: assert property (
    rd && addr == `PP_RDR_OFS |=> rdata == $past(s_q.cfg.pp_rdr))
    else $error("port P drive strength read wrong");

  pp_pull_read_a: assert property (
    rd && addr == `PP_PULL_EN_OFS |=> rdata == $past(s_q.cfg.pp_pull_en))
    else $error("port P pull enable read wrong");

  pp_sel_read_a: assert property (
    rd && addr == `PP_PULL_SEL_OFS |=> rdata == $past(s_q.cfg.pp_pull_sel))
    else $error("port P pull select read wrong");

  data_write_a: assert property (
    wr && addr == `PP_DATA_OFS |=> s_q.cfg.pp_data == $past(wdata))
    else $error("port P data latch write lost");

  dir_write_a: assert property (
    wr && addr == `PP_DIR_OFS |=> s_q.cfg.pp_dir == $past(wdata))
    else $error("port P direction write lost");

  pm_en_write_a: assert property (
    wr && addr == `PM_PULL_EN_OFS |=> s_q.cfg.pm_pull_en == $past(wdata[`PM_W-1:0]))
    else $error("port M pull enable write lost");
endmodule : port_pin_config_regs

// file: tb/pad_pin_model.sv
`timescale 1ns/1ps
module pad_pin_model (
  // clock
  input  wire logic       ref_clk,
  // pad controls from the block
  input  wire logic [7:0] oe,
  input  wire logic [7:0] out,
  input  wire logic [7:0] pull_en,
  input  wire logic [7:0] pull_sel,
  // outside driver
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  // pin levels
  output logic      [7:0] pin
);
  logic [7:0] flt_q = 8'h00;
  // a floating pin never keeps its last level
  always @(posedge ref_clk) flt_q <= ~pin;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (ext_en[i]) pin[i] = ext_val[i];        // outside driver wins, a short
      else if (oe[i]) pin[i] = out[i];
      else if (pull_en[i]) pin[i] = ~pull_sel[i];
      else pin[i] = flt_q[i];
    end
  end
endmodule : pad_pin_model

// file: tb/testbench.sv
`timescale 1ns/1ps
`include "port_pin_map.svh"
module testbench;
  import port_pin_pkg::*;
  logic       ref_clk;
  logic       rst_b;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic [5:0] m_dir, m_dout, m_oe, m_out, m_od, m_pen, m_psel;
  logic [7:0] p_pin, p_oe, p_out, p_rdr, p_pen, p_psel, ext_en, ext_val;
  int         errors;
  int         num_checks;
  int         cycles;

  port_pin_config_regs port_pin_config_regs_inst (
    .ref_clk(ref_clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .portm_dir_in(m_dir), .portm_dout_in(m_dout), .portm_oe(m_oe),
    .portm_out(m_out), .portm_od(m_od), .portm_pull_en(m_pen), .portm_pull_sel(m_psel),
    .portp_pin_in(p_pin), .portp_oe(p_oe), .portp_out(p_out), .portp_rdr(p_rdr),
    .portp_pull_en(p_pen), .portp_pull_sel(p_psel));

  pad_pin_model pad_pin_model_inst (
    .ref_clk(ref_clk), .oe(p_oe), .out(p_out), .pull_en(p_pen), .pull_sel(p_psel),
    .ext_en(ext_en), .ext_val(ext_val), .pin(p_pin));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge ref_clk);
    wr    <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge ref_clk);
    rd   <= 1'b0;
    #1 chk(rdata, exp, "read data");
  endtask : reg_rd

  // pad outputs follow config two edges after the write
  task automatic settle;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask : settle

  task automatic t_reset;
    settle();
    chk({2'b00, m_pen}, 8'h3f, "m pull en");
    chk({2'b00, m_psel}, 8'h00, "m pull sel");
    chk(p_pen, 8'h00, "p pull en");
    reg_rd(`PM_PULL_EN_OFS, 8'h3f);
    reg_rd(`PP_PULL_EN_OFS, 8'h00);
  endtask : t_reset

  task automatic t_regs;
    logic [7:0] ofs [7];
    logic [7:0] msk;
    ofs = '{`PM_PULL_EN_OFS, `PM_PULL_SEL_OFS, `PM_OD_OFS, `PP_DIR_OFS,
            `PP_RDR_OFS, `PP_PULL_EN_OFS, `PP_PULL_SEL_OFS};
    foreach (ofs[i]) begin
      msk = (ofs[i] < 8'h18) ? 8'h3f : 8'hff;
      reg_wr(ofs[i], 8'hc3);
      reg_rd(ofs[i], 8'hc3 & msk);
      reg_wr(ofs[i], 8'h00);
      reg_rd(ofs[i], 8'h00);
    end
    reg_wr(8'h17, 8'hff);
    reg_rd(8'h17, 8'h00);
  endtask : t_regs

  task automatic t_portp;
    @(posedge ref_clk);
    ext_en  <= 8'h83;
    ext_val <= 8'h01;
    reg_wr(`PP_DATA_OFS, 8'ha5);
    reg_wr(`PP_DIR_OFS, 8'hf0);
    reg_wr(`PP_RDR_OFS, 8'hff);
    reg_wr(`PP_PULL_EN_OFS, 8'hff);
    reg_wr(`PP_PULL_SEL_OFS, 8'h0c);
    settle();
    chk(p_oe, 8'hf0, "p oe");
    chk(p_out, 8'ha5, "p out");
    chk(p_rdr, 8'hf0, "p rdr");
    chk(p_pen, 8'h0f, "p pull en");
    chk(p_psel, 8'h0c, "p pull sel");
    reg_rd(`PP_LEVEL_OFS, 8'h21);
    reg_rd(`PP_DATA_OFS, 8'ha1);
    reg_wr(`PP_LEVEL_OFS, 8'hff);
    reg_rd(`PP_LEVEL_OFS, 8'h21);
    reg_wr(`PP_DIR_OFS, 8'h0f);
    settle();
    chk(p_rdr, 8'h0f, "p rdr");
    chk(p_pen, 8'hf0, "p pull en");
    reg_rd(`PP_DATA_OFS, 8'h75);
  endtask : t_portp

  task automatic t_portm;
    @(posedge ref_clk);
    m_dir  <= 6'h0f;
    m_dout <= 6'h33;
    reg_wr(`PM_PULL_EN_OFS, 8'h3f);
    reg_wr(`PM_PULL_SEL_OFS, 8'h21);
    reg_wr(`PM_OD_OFS, 8'h25);
    settle();
    chk({2'b00, m_od}, 8'h05, "m od");
    chk({2'b00, m_oe}, 8'h0e, "m oe");
    chk({2'b00, m_out}, 8'h12, "m out");
    chk({2'b00, m_pen}, 8'h34, "m pull en");
    chk({2'b00, m_psel}, 8'h21, "m pull sel");
  endtask : t_portm

  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      test_done();
    end
  end

  initial begin
    rst_b   = 1'b0;
    addr    = 8'h00;
    wdata   = 8'h00;
    wr      = 1'b0;
    rd      = 1'b0;
    m_dir   = 6'h00;
    m_dout  = 6'h00;
    ext_en  = 8'h00;
    ext_val = 8'h00;
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_reset();
    t_regs();
    t_portp();
    t_portm();
    test_done();
  end
endmodule : testbench
